//--- rtl/uphy_params.svh
// Purpose: Offsets, field positions, reset values and counts of the transceiver control register bank.
// Assumes: Byte addresses on an APB bus with 32-bit data, one aligned word per register.
// Notes: Definitions only.
`ifndef UPHY_PARAMS_SVH
`define UPHY_PARAMS_SVH

`define UPHY_OFF_EP_TAG 8'h34
`define UPHY_OFF_OTG_MASK 8'h38
`define UPHY_OFF_PWR_SIG 8'h3C
`define UPHY_OFF_CTRL 8'h40
`define UPHY_OFF_IRQ_STAT 8'h44
`define UPHY_OFF_IRQ_MASK 8'h48
`define UPHY_OFF_LINE_STAT 8'h4C

`define UPHY_WMASK_EP_TAG 32'h0000_FFFF
`define UPHY_WMASK_OTG 32'hFFFF_FFFF
`define UPHY_WMASK_PWR 32'h0000_01FF
`define UPHY_WMASK_CTRL 32'h0004_3FF0
`define UPHY_WMASK_IRQ 32'h0000_0007
`define UPHY_RST_VAL 32'h0000_0000

`define UPHY_CTRL_PD_DIS 18
`define UPHY_CTRL_SE0_FLAG 13
`define UPHY_CTRL_K_FLAG 12
`define UPHY_CTRL_FILT_MSB 11
`define UPHY_CTRL_FILT_LSB 8
`define UPHY_CTRL_SUSP_EN 7
`define UPHY_CTRL_CONF_MSB 6
`define UPHY_CTRL_CONF_LSB 4
`define UPHY_PWR_VALID 8

`define UPHY_IRQ_SE0 0
`define UPHY_IRQ_K 1
`define UPHY_IRQ_LINE 2

`define UPHY_TAG_OR 5'h10
`define UPHY_LS_SE0 2'h0
`define UPHY_LS_K 2'h2
`define UPHY_FILT_CNT_W 17

`endif

//--- rtl/uphy_pkg.sv
// Purpose: Types shared by the transceiver control register bank.
// Assumes: Nothing beyond the parameter header.
// Notes: Types only; numbers live in the header.
package uphy_pkg;

  typedef enum logic [2:0] {
    ST_AWAKE = 3'b001,
    ST_SUSP = 3'b010,
    ST_WAKE = 3'b100
  } uphy_state_t;

  typedef struct packed {
    logic valid;
    logic [3:0] ep;
  } uphy_rx_ep_t;

  typedef struct packed {
    logic valid;
    logic [4:0] ep;
  } uphy_rx_tag_t;

  typedef struct packed {
    logic pulldown_disable;
    logic [2:0] transceiver_config_pins;
  } uphy_phy_ctl_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } uphy_pwr_sig_t;

endpackage

//--- rtl/uphy_line_filter.sv
// Purpose: Holds back a line state change until it has stood for two to the power of the filter field clocks.
// Assumes: raw is already synchronised to clock.
// Notes: A change that does not last restarts the wait, so glitches never reach filt.
`timescale 1ns/1ps
module uphy_line_filter #(
  parameter int CNT_W = 17
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] raw,
  input wire logic [3:0] log2,
  output logic [1:0] filt,
  output logic changed
);

  logic [1:0] cand_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] limit;

  generate
    if (CNT_W < 17) begin : g_bad_width
      $error("uphy_line_filter needs CNT_W of at least 17");
    end
  endgenerate

  // The wait is counted from the edge that first samples the new value.
  assign limit = {{(CNT_W-1){1'b0}}, 1'b1} << log2;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cand_reg <= 2'h0;
      cnt_reg <= '0;
      filt <= 2'h0;
      changed <= 1'b0;
    end else begin
      changed <= 1'b0;
      if (raw != cand_reg) begin
        cand_reg <= raw;
        cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (cand_reg != filt) begin
        if (cnt_reg >= limit) begin
          filt <= cand_reg;
          changed <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

endmodule

//--- rtl/uphy_ctrl_regs.sv
// Purpose: Upper register bank of the USB interface manager with endpoint tagging and transceiver control.
// Assumes: APB slave with zero wait states; line state arrives from the transceiver pins, asynchronously.
// Notes: Suspend, receive endpoint and software registers all run on the one interface clock.
// Behaviour
// - Endpoints with their mask bit set appear on the receive port ORed with 0x10.
// - Control bit 18 set disables the pulldowns through the one pulldown_disable bit of phy_ctl.
// - Auto-resume from SE0 sets control bit 13 until software writes zero.
// - Auto-resume from K sets control bit 12 until software writes zero.
// - Line state changes propagate after two to the filter field clocks.
// - Bit 7 lets the suspend controller resume; otherwise software polls filtered line state.
// - Control bits 6 to 4 drive the three transceiver configuration pins.
`timescale 1ns/1ps
`include "uphy_params.svh"
module uphy_ctrl_regs #(
  parameter int NUM_EP = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] linestate,
  input wire logic suspend_req,
  input wire uphy_pkg::uphy_rx_ep_t rx_in,
  output uphy_pkg::uphy_rx_tag_t rx_out,
  output uphy_pkg::uphy_phy_ctl_t phy_ctl,
  output uphy_pkg::uphy_pwr_sig_t pwr_sig,
  output logic [31:0] otg_flag_mask,
  output logic resume_wake,
  output logic irq
);
  import uphy_pkg::*;

  generate
    if (NUM_EP != 16) begin : g_bad_ep
      $error("uphy_ctrl_regs serves exactly 16 endpoints");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic [31:0] ep_tag_reg;
  logic [31:0] otg_reg;
  logic [31:0] pwr_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [31:0] irq_stat_reg;
  logic [31:0] irq_stat_next;
  logic [31:0] irq_mask_reg;
  logic [31:0] line_stat;
  logic [31:0] rd_mux;
  logic [31:0] wr_bytes;
  logic [1:0] ls_meta_reg;
  logic [1:0] ls_sync_reg;
  logic [1:0] ls_filt;
  logic ls_changed;
  logic set_se0;
  logic set_k;
  uphy_state_t state_reg;
  uphy_state_t state_next;

  wire hit_ep = paddr == `UPHY_OFF_EP_TAG;
  wire hit_otg = paddr == `UPHY_OFF_OTG_MASK;
  wire hit_pwr = paddr == `UPHY_OFF_PWR_SIG;
  wire hit_ctrl = paddr == `UPHY_OFF_CTRL;
  wire hit_stat = paddr == `UPHY_OFF_IRQ_STAT;
  wire hit_mask = paddr == `UPHY_OFF_IRQ_MASK;
  wire hit_line = paddr == `UPHY_OFF_LINE_STAT;
  wire hit_any = hit_ep | hit_otg | hit_pwr | hit_ctrl | hit_stat | hit_mask | hit_line;
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite & hit_any;
  wire wr_ep = wr & hit_ep;
  wire wr_otg = wr & hit_otg;
  wire wr_pwr = wr & hit_pwr;
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_stat = wr & hit_stat;
  wire wr_mask = wr & hit_mask;

  // Zero wait states: every access phase completes in its first cycle.
  assign pready = 1'b1;
  assign pslverr = access & ~hit_any;

  // Byte strobes widen to a bit mask so partial writes touch only their lanes.
  assign wr_bytes = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  assign line_stat = {28'h0, state_reg == ST_SUSP, 1'b0, ls_filt};

  assign rd_mux = hit_ep ? ep_tag_reg :
                  hit_otg ? otg_reg :
                  hit_pwr ? pwr_reg :
                  hit_ctrl ? ctrl_reg :
                  hit_stat ? irq_stat_reg :
                  hit_mask ? irq_mask_reg :
                  hit_line ? line_stat : 32'h0000_0000;

  // Read data is latched in the setup cycle and stands during the access cycle.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= `UPHY_RST_VAL;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Plain read/write registers.

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wmask);
    merge = (old & ~(wmask & wr_bytes)) | (pwdata & wmask & wr_bytes);
  endfunction

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ep_tag_reg <= `UPHY_RST_VAL;
      otg_reg <= `UPHY_RST_VAL;
      pwr_reg <= `UPHY_RST_VAL;
      irq_mask_reg <= `UPHY_RST_VAL;
    end else begin
      if (wr_ep) ep_tag_reg <= merge(ep_tag_reg, `UPHY_WMASK_EP_TAG);
      if (wr_otg) otg_reg <= merge(otg_reg, `UPHY_WMASK_OTG);
      if (wr_pwr) pwr_reg <= merge(pwr_reg, `UPHY_WMASK_PWR);
      if (wr_mask) irq_mask_reg <= merge(irq_mask_reg, `UPHY_WMASK_IRQ);
    end
  end

  assign otg_flag_mask = otg_reg;
  assign pwr_sig = '{valid: pwr_reg[`UPHY_PWR_VALID], data: pwr_reg[7:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Transceiver control with hardware-set resume cause flags.

  // A write of zero clears a cause flag; the hardware set wins if both land together.
  always_comb begin
    ctrl_next = wr_ctrl ? merge(ctrl_reg, `UPHY_WMASK_CTRL) : ctrl_reg;
    if (wr_ctrl & ~pstrb[1]) begin
      ctrl_next[`UPHY_CTRL_SE0_FLAG] = ctrl_reg[`UPHY_CTRL_SE0_FLAG];
      ctrl_next[`UPHY_CTRL_K_FLAG] = ctrl_reg[`UPHY_CTRL_K_FLAG];
    end else if (wr_ctrl) begin
      ctrl_next[`UPHY_CTRL_SE0_FLAG] = ctrl_reg[`UPHY_CTRL_SE0_FLAG] & pwdata[`UPHY_CTRL_SE0_FLAG];
      ctrl_next[`UPHY_CTRL_K_FLAG] = ctrl_reg[`UPHY_CTRL_K_FLAG] & pwdata[`UPHY_CTRL_K_FLAG];
    end
    if (set_se0) ctrl_next[`UPHY_CTRL_SE0_FLAG] = 1'b1;
    if (set_k) ctrl_next[`UPHY_CTRL_K_FLAG] = 1'b1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `UPHY_RST_VAL;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phy_ctl <= '0;
    end else begin
      phy_ctl.pulldown_disable <= ctrl_next[`UPHY_CTRL_PD_DIS];
      phy_ctl.transceiver_config_pins <= ctrl_next[`UPHY_CTRL_CONF_MSB:`UPHY_CTRL_CONF_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line state synchroniser, filter and suspend controller.

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ls_meta_reg <= 2'h0;
      ls_sync_reg <= 2'h0;
    end else begin
      ls_meta_reg <= linestate;
      ls_sync_reg <= ls_meta_reg;
    end
  end

  uphy_line_filter #(
    .CNT_W(`UPHY_FILT_CNT_W)
  ) u_filter (
    .clock(clock),
    .rst(rst),
    .raw(ls_sync_reg),
    .log2(ctrl_reg[`UPHY_CTRL_FILT_MSB:`UPHY_CTRL_FILT_LSB]),
    .filt(ls_filt),
    .changed(ls_changed)
  );

  wire susp_en = ctrl_reg[`UPHY_CTRL_SUSP_EN];
  wire ls_is_se0 = ls_filt == `UPHY_LS_SE0;
  wire ls_is_k = ls_filt == `UPHY_LS_K;
  assign set_se0 = (state_reg == ST_SUSP) & susp_en & ls_is_se0;
  assign set_k = (state_reg == ST_SUSP) & susp_en & ls_is_k;

  // Without the enable the controller never holds suspend; software watches the line itself.
  always_comb begin
    case (state_reg)
      ST_AWAKE: state_next = (susp_en & suspend_req & ~ls_is_se0 & ~ls_is_k) ? ST_SUSP : ST_AWAKE;
      ST_SUSP: begin
        if (~susp_en) begin
          state_next = ST_AWAKE;
        end else if (set_se0 | set_k) begin
          state_next = ST_WAKE;
        end else begin
          state_next = ST_SUSP;
        end
      end
      ST_WAKE: state_next = ST_AWAKE;
      default: state_next = ST_AWAKE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ST_AWAKE;
      resume_wake <= 1'b0;
    end else begin
      state_reg <= state_next;
      resume_wake <= state_next == ST_WAKE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive endpoint tagging.

  wire ep_marked = ep_tag_reg[rx_in.ep];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_out <= '0;
    end else begin
      rx_out.valid <= rx_in.valid;
      if (rx_in.valid) begin
        rx_out.ep <= {1'b0, rx_in.ep} | (ep_marked ? `UPHY_TAG_OR : 5'h00);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky causes, cleared by writing one, set wins.

  wire [31:0] irq_set = {29'h0, ls_changed, set_k, set_se0};

  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_stat) irq_stat_next = irq_stat_reg & ~(pwdata & wr_bytes & `UPHY_WMASK_IRQ);
    irq_stat_next = irq_stat_next | irq_set;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= `UPHY_RST_VAL;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq <= |(irq_stat_next & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_rx_tag_or: assert property (
    rx_in.valid |=> rx_out.valid && rx_out.ep == ({1'b0, $past(rx_in.ep)} | ($past(ep_marked) ? 5'h10 : 5'h00)))
    else $error("receive endpoint tag wrong");

  a_pulldown_write: assert property (
    wr_ctrl && pstrb[2] |=> phy_ctl.pulldown_disable == $past(pwdata[18]))
    else $error("pulldown disable did not follow write");

  a_se0_cause_set: assert property (
    state_reg == ST_SUSP && susp_en && ls_filt == 2'h0 |=> ctrl_reg[13] && state_reg == ST_WAKE && resume_wake)
    else $error("SE0 resume cause not recorded");

  a_se0_flag_hold: assert property (
    ctrl_reg[13] && !(wr_ctrl && pstrb[1] && !pwdata[13]) |=> ctrl_reg[13])
    else $error("SE0 cause flag dropped without a clear");

  a_k_cause_set: assert property (
    state_reg == ST_SUSP && susp_en && ls_filt == 2'h2 |=> ctrl_reg[12] && state_reg == ST_WAKE && resume_wake)
    else $error("K resume cause not recorded");

  a_filter_source: assert property (
    ls_filt != $past(ls_filt) |-> ls_changed && ls_filt == $past(ls_sync_reg))
    else $error("filtered line state took an unseen value");

  a_suspend_gate: assert property (
    !susp_en |=> state_reg != ST_SUSP && (!ctrl_reg[13] || $past(ctrl_reg[13])) &&
      (!ctrl_reg[12] || $past(ctrl_reg[12])))
    else $error("suspend held without the enable");

  a_config_pins: assert property (
    wr_ctrl && pstrb[0] |=> phy_ctl.transceiver_config_pins == $past(pwdata[6:4]))
    else $error("configuration pins did not follow write");

  a_reserved_zero: assert property (
    setup && !pwrite && hit_ctrl |=> prdata[31:19] == 13'h0 && prdata[17:14] == 4'h0 && prdata[3:0] == 4'h0)
    else $error("reserved control bits read non-zero");

endmodule

//--- verification/uphy_xcvr_model.sv
// Purpose: Transceiver and host side model that drives the line state pins.
// Assumes: The bench commands the bus state it wants the host to signal.
// Notes: The line is driven at every edge, so it never floats or holds stale values.
`timescale 1ns/1ps
module uphy_xcvr_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] bus_state,
  output logic [1:0] linestate
);
  import uphy_pkg::*;
  // The host holds SE0 during reset and later signals J, K or SE0 as told.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      linestate <= 2'h0;
    end else begin
      linestate <= bus_state;
    end
  end
endmodule

//--- verification/uphy_ctrl_regs_tb_top.sv
// Purpose: Self-checking bench for the transceiver control register bank.
// Assumes: APB master with one idle cycle between transfers.
// Notes: Table rows cover field access; hand-written cases cover filter, suspend and tags.
`timescale 1ns/1ps
`include "uphy_params.svh"
module uphy_ctrl_regs_tb_top;
  import uphy_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic err;} uphy_row_t;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, suspend_req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, otg, d;
  logic [3:0] pstrb = 4'hF;
  logic [1:0] linestate, bus_state = 2'h0;
  logic pready, pslverr, resume_wake, irq, e;
  uphy_rx_ep_t rx_in = 5'h00;
  uphy_rx_tag_t rx_out;
  uphy_phy_ctl_t phy_ctl;
  uphy_pwr_sig_t pwr_sig;
  int bad_count = 0, n_checks = 0, cyc_n = 0, wake_n = 0;
  uphy_row_t rows [7] = '{'{8'h34, 32'hFFFF_FFFF, 32'h0000_FFFF, 1'b0},
    '{8'h38, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 1'b0}, '{8'h3C, 32'hFFFF_FFFF, 32'h0000_01FF, 1'b0},
    '{8'h40, 32'hFFFF_FFFF, 32'h0004_0FF0, 1'b0}, '{8'h48, 32'hFFFF_FFFF, 32'h0000_0007, 1'b0},
    '{8'h4C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0}, '{8'h50, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
  logic [1:0] cs [2] = '{2'h2, 2'h0};
  logic [31:0] cf [2] = '{32'h1000, 32'h2000};
  logic [31:0] ci [2] = '{32'h2, 32'h1};

  uphy_ctrl_regs uphy_ctrl_regs_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .linestate(linestate), .suspend_req(suspend_req), .rx_in(rx_in),
    .rx_out(rx_out), .phy_ctl(phy_ctl), .pwr_sig(pwr_sig), .otg_flag_mask(otg),
    .resume_wake(resume_wake), .irq(irq));
  uphy_xcvr_model uphy_xcvr_model_i (.clock(clock), .rst(rst), .bus_state(bus_state),
    .linestate(linestate));

  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc_n++;
    if (resume_wake === 1'b1) wake_n++;
    if (cyc_n == 5000) begin
      bad_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, g, x);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Each transfer starts on a fresh edge, so a release and the next setup never share a step.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask
  task rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(8'h34 + 8'(4 * i));
      chk(d, 32'h0);
    end
    chk({9'h0, phy_ctl, pwr_sig, irq, resume_wake, 8'h0}, 32'h0);
    chk(otg, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(d, rows[i].e);
      chk({31'h0, e}, {31'h0, rows[i].err});
    end
    chk({28'h0, phy_ctl}, 32'hF);
    chk({23'h0, pwr_sig}, 32'h1FF);
    chk(otg, 32'hA5A5_5A5A);
    wr(`UPHY_OFF_CTRL, 32'h0000_0050);
    #1 chk({28'h0, phy_ctl}, 32'h5);
    $display("table test done");
    wr(`UPHY_OFF_EP_TAG, 32'h0000_0008);
    @(posedge clock);
    rx_in <= {1'b1, 4'h3};
    @(posedge clock);
    rx_in <= {1'b1, 4'h4};
    #1 chk({26'h0, rx_out}, 32'h33);
    @(posedge clock);
    rx_in <= 5'h00;
    #1 chk({26'h0, rx_out}, 32'h24);
    @(posedge clock);
    #1 chk({26'h0, rx_out}, 32'h04);
    $display("tag test done");
    // A filter field of three gives eight clocks, so the early read still sees SE0.
    wr(`UPHY_OFF_CTRL, 32'h0000_0300);
    wr(`UPHY_OFF_IRQ_STAT, 32'h7);
    @(posedge clock);
    bus_state <= 2'h1;
    cyc(3);
    rd(`UPHY_OFF_LINE_STAT);
    chk(d, 32'h0);
    cyc(12);
    rd(`UPHY_OFF_LINE_STAT);
    chk(d, 32'h1);
    rd(`UPHY_OFF_IRQ_STAT);
    chk(d, 32'h4);
    chk({31'h0, irq}, 32'h1);
    $display("filter test done");
    wr(`UPHY_OFF_CTRL, 32'h0000_0000);
    suspend_req <= 1'b1;
    cyc(4);
    rd(`UPHY_OFF_LINE_STAT);
    chk(d, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wr(`UPHY_OFF_CTRL, 32'h0000_0080);
      cyc(4);
      rd(`UPHY_OFF_LINE_STAT);
      chk(d, 32'h9);
      suspend_req <= 1'b0;
      wr(`UPHY_OFF_IRQ_MASK, 32'h0);
      wr(`UPHY_OFF_IRQ_STAT, 32'h7);
      bus_state <= cs[k];
      cyc(10);
      rd(`UPHY_OFF_CTRL);
      chk(d, 32'h80 | cf[k]);
      chk({31'h0, irq}, 32'h0);
      chk(wake_n, k + 1);
      rd(`UPHY_OFF_IRQ_STAT);
      chk(d, ci[k] | 32'h4);
      wr(`UPHY_OFF_IRQ_MASK, ci[k]);
      cyc(2);
      chk({31'h0, irq}, 32'h1);
      wr(`UPHY_OFF_IRQ_STAT, 32'h7);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      wr(`UPHY_OFF_CTRL, 32'h80 | cf[k]);
      rd(`UPHY_OFF_CTRL);
      chk(d, 32'h80 | cf[k]);
      wr(`UPHY_OFF_CTRL, 32'h0000_0080);
      rd(`UPHY_OFF_CTRL);
      chk(d, 32'h80);
      bus_state <= 2'h1;
      suspend_req <= 1'b1;
      cyc(6);
    end
    $display("suspend test done");
    rd(`UPHY_OFF_LINE_STAT);
    chk(d, 32'h9);
    wr(`UPHY_OFF_CTRL, 32'h0000_0000);
    rd(`UPHY_OFF_LINE_STAT);
    chk(d, 32'h1);
    rd(`UPHY_OFF_CTRL);
    chk(d, 32'h0);
    $display("suspend release test done");
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    chk({9'h0, phy_ctl, pwr_sig, irq, resume_wake, 8'h0}, 32'h0);
    chk(otg, 32'h0);
    rd(`UPHY_OFF_EP_TAG);
    chk(d, 32'h0);
    $display("mid-run reset test done");
    results();
  end
endmodule
